// *** rtl/fan_two_pkg.sv ***
// Constants for the second fan output control block: register map,
// field positions, reset values and spin-up timing.
// Assumes a single 20 MHz clock and byte-wide register access.
package fan_two_pkg;

   // ****************************************************************
   // Register offsets and reset values
   // ****************************************************************
   localparam logic [7:0] source_select_addr   = 8'hCC;
   localparam logic [7:0] override_lock_addr   = 8'hCD;
   localparam logic [7:0] spinup_config_addr   = 8'hCE;
   localparam logic [7:0] source_select_reset  = 8'h00;
   localparam logic [7:0] override_lock_reset  = 8'h00;
   localparam logic [7:0] spinup_config_reset  = 8'h00;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int zone_bind_lsb          = 0;
   localparam int processor_hot_bind_bit = 4;
   localparam int regulator_hot_bind_bit = 6;
   localparam int manual_enable_bit      = 0;
   localparam int polarity_invert_bit    = 1;
   localparam int hot_lock_enable_bit    = 2;
   localparam int hot_lock_flag_bit      = 3;
   localparam int manual_level_lsb       = 4;
   localparam int spinup_level_lsb       = 0;
   localparam int spinup_dur_msb_bit     = 4;
   localparam int spinup_dur_low_lsb     = 5;

   // ****************************************************************
   // Duty and timing
   // ****************************************************************
   localparam logic [7:0] duty_zero        = 8'h00;
   localparam logic [7:0] duty_full        = 8'hFF;
   localparam logic [7:0] ramp_step        = 8'h01;
   localparam int         clock_period_ns  = 50;
   localparam int         ms_time_ns       = 1000000;
   localparam int         ms_tick_cycles   = ms_time_ns / clock_period_ns;

   // Spin-up duration per four-bit code, in milliseconds
   localparam logic [14:0] spinup_ms_table [16] = '{
      15'h0000, 15'h0064, 15'h00FA, 15'h0190, 15'h02BC, 15'h03E8, 15'h07D0, 15'h0FA0,
      15'h1770, 15'h1F40, 15'h2710, 15'h2EE0, 15'h36B0, 15'h3E80, 15'h4650, 15'h4E20};

endpackage : fan_two_pkg

// *** rtl/fan_two_wave.sv ***
// Waveform generator for the second fan output.
// Assumes duty arrives registered on the same clock; frequency is fixed.
module fan_two_wave (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Duty and polarity
   input  wire logic [7:0] duty,
   input  wire logic       invert,
   // Pin
   output logic            fan_pin
);

   logic [7:0] count_reg;
   logic       high_next;

   // ****************************************************************
   // Period counter and compare
   // ****************************************************************
   // Counter wraps at 254 so that duty_full alone means always active
   assign high_next = (duty == fan_two_pkg::duty_full) || (count_reg < duty);

   // Period counter
   always_ff @(posedge clock) begin
      if (reset || count_reg == 8'hFE) begin
         count_reg <= 8'h00;
      end else begin
         count_reg <= count_reg + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         fan_pin <= 1'b0;
      end else begin
         fan_pin <= high_next ^ invert;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_FULL_HIGH: assert property (@(posedge clock) disable iff (reset)
      (duty == fan_two_pkg::duty_full && !invert) |=> fan_pin)
      else $error("full duty not high with normal polarity");
   AST_FULL_LOW: assert property (@(posedge clock) disable iff (reset)
      (duty == fan_two_pkg::duty_full && invert) |=> !fan_pin)
      else $error("full duty not low with inverted polarity");

endmodule : fan_two_wave

// *** rtl/fan_two_control.sv ***
// Control logic for the second fan output: source binding, maximum
// selection, manual override, hot lock, spin-up and register access.
// Assumes zone duties come from table logic on this clock, overheat
// inputs are asynchronous active-high pins, and a register port sits
// behind the management bus interface.
module fan_two_control #(
   parameter int           ms_tick_cycles   = fan_two_pkg::ms_tick_cycles,
   parameter logic [127:0] low_freq_table   = 128'hFFEEDDCCBBAA99887766554433221100,
   parameter logic [127:0] high_freq_table  = 128'hFFFFFFF0E0D0C0B0A090807060504000
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // Global configuration
   input  wire logic       config_lock,
   input  wire logic       high_freq_map_select,
   // Duty sources
   input  wire logic [7:0] zone_duty_one,
   input  wire logic [7:0] zone_duty_two,
   input  wire logic [7:0] zone_duty_three,
   input  wire logic [7:0] zone_duty_four,
   input  wire logic       processor_overheat_input,
   input  wire logic       regulator_overheat_input,
   // Fan pin
   output logic            fan_output_two
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]  source_select_reg;
   logic [7:0]  override_ctl_reg;
   logic [7:0]  spinup_config_reg;
   logic        hot_lock_flag_reg;
   logic [7:0]  duty_reg;
   logic [7:0]  base_duty_reg;
   logic [14:0] tick_count_reg;
   logic        ms_tick_reg;
   logic [14:0] spin_ms_reg;
   logic [1:0]  sync1_reg;
   logic [1:0]  sync2_reg;
   logic [1:0]  sync3_reg;
   logic [1:0]  hot_stable_reg;
   logic [7:0]  ramp_reg [2];

   logic [3:0]  zone_table_bind;
   logic        processor_hot_bind;
   logic        regulator_hot_bind;
   logic [1:0]  hot_bind;
   logic        manual_duty_enable;
   logic        output_polarity_invert;
   logic        hot_lock_enable;
   logic [3:0]  manual_duty_level;
   logic [3:0]  spinup_duty_level;
   logic [3:0]  spinup_duration_code;
   logic [7:0]  override_duty;
   logic [7:0]  spinup_duty;
   logic [7:0]  zone_max;
   logic [7:0]  ramp_max;
   logic [7:0]  base_duty;
   logic [7:0]  duty_next;
   logic        spin_active;
   logic        spin_trigger;
   logic        spinning;
   logic        write_source;
   logic        write_override_any;
   logic        write_override_cfg;
   logic        write_spinup;
   logic        lock_set;
   logic        lock_clear;
   logic [3:0]  applied_code;
   logic [7:0]  override_read;
   logic [7:0]  read_value;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // code table
   function automatic logic [7:0] code_to_duty(input logic [3:0] code, input logic hf);
      code_to_duty = hf ? high_freq_table[{code, 3'b000} +: 8] : low_freq_table[{code, 3'b000} +: 8];
   endfunction : code_to_duty

   // Largest code whose duty does not exceed the given duty
   function automatic logic [3:0] duty_to_code(input logic [7:0] duty, input logic hf);
      logic [3:0] result;
      result = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (code_to_duty(4'(i), hf) <= duty) begin
            result = 4'(i);
         end
      end
      duty_to_code = result;
   endfunction : duty_to_code

   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      max8 = (a > b) ? a : b;
   endfunction : max8

   // ****************************************************************
   // Field decode
   // ****************************************************************
   // zone bind bits
   assign zone_table_bind        = source_select_reg[fan_two_pkg::zone_bind_lsb +: 4];
   assign processor_hot_bind     = source_select_reg[fan_two_pkg::processor_hot_bind_bit];
   assign regulator_hot_bind     = source_select_reg[fan_two_pkg::regulator_hot_bind_bit];
   assign hot_bind               = {regulator_hot_bind, processor_hot_bind};
   assign manual_duty_enable     = override_ctl_reg[fan_two_pkg::manual_enable_bit];
   assign output_polarity_invert = override_ctl_reg[fan_two_pkg::polarity_invert_bit];
   assign hot_lock_enable        = override_ctl_reg[fan_two_pkg::hot_lock_enable_bit];
   assign manual_duty_level      = override_ctl_reg[fan_two_pkg::manual_level_lsb +: 4];
   assign spinup_duty_level      = spinup_config_reg[fan_two_pkg::spinup_level_lsb +: 4];
   assign spinup_duration_code   = {spinup_config_reg[fan_two_pkg::spinup_dur_msb_bit],
                                    spinup_config_reg[fan_two_pkg::spinup_dur_low_lsb +: 3]};

   // ****************************************************************
   // Overheat input synchronisers
   // ****************************************************************
   // Three stages; a level counts once the second and third agree
   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_reg      <= 2'b00;
         sync2_reg      <= 2'b00;
         sync3_reg      <= 2'b00;
         hot_stable_reg <= 2'b00;
      end else begin
         sync1_reg      <= {regulator_overheat_input, processor_overheat_input};
         sync2_reg      <= sync1_reg;
         sync3_reg      <= sync2_reg;
         hot_stable_reg <= (sync2_reg & sync3_reg) | (hot_stable_reg & (sync2_reg | sync3_reg));
      end
   end

   // ****************************************************************
   // Millisecond tick
   // ****************************************************************
   // Shared time base keeps the spin-up counter only 15 bits wide
   always_ff @(posedge clock) begin
      if (reset || tick_count_reg == 15'(ms_tick_cycles - 1)) begin
         tick_count_reg <= 15'h0000;
      end else begin
         tick_count_reg <= tick_count_reg + 15'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ms_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg <= (tick_count_reg == 15'(ms_tick_cycles - 1));
      end
   end

   // ****************************************************************
   // Overheat ramps
   // ****************************************************************
   // ramp up and down
   for (genvar g = 0; g < 2; g++) begin : gen_ramp
      always_ff @(posedge clock) begin
         if (reset) begin
            ramp_reg[g] <= fan_two_pkg::duty_zero;
         end else if (ms_tick_reg && hot_stable_reg[g] && hot_bind[g]) begin
            ramp_reg[g] <= (ramp_reg[g] > fan_two_pkg::duty_full - fan_two_pkg::ramp_step)
                           ? fan_two_pkg::duty_full : ramp_reg[g] + fan_two_pkg::ramp_step;
         end else if (ms_tick_reg) begin
            ramp_reg[g] <= (ramp_reg[g] < fan_two_pkg::ramp_step)
                           ? fan_two_pkg::duty_zero : ramp_reg[g] - fan_two_pkg::ramp_step;
         end
      end
   end

   // ****************************************************************
   // Duty resolution
   // ****************************************************************
   // manual level mapping
   assign override_duty = manual_duty_enable ? code_to_duty(manual_duty_level, high_freq_map_select)
                                             : fan_two_pkg::duty_zero;
   assign spinup_duty   = code_to_duty(spinup_duty_level, high_freq_map_select);
   assign zone_max = max8(max8(zone_table_bind[0] ? zone_duty_one   : fan_two_pkg::duty_zero,
                               zone_table_bind[1] ? zone_duty_two   : fan_two_pkg::duty_zero),
                          max8(zone_table_bind[2] ? zone_duty_three : fan_two_pkg::duty_zero,
                               zone_table_bind[3] ? zone_duty_four  : fan_two_pkg::duty_zero));
   assign ramp_max = max8(processor_hot_bind ? ramp_reg[0] : fan_two_pkg::duty_zero,
                          regulator_hot_bind ? ramp_reg[1] : fan_two_pkg::duty_zero);
   assign base_duty = hot_lock_flag_reg ? fan_two_pkg::duty_full
                                        : max8(max8(zone_max, ramp_max), override_duty);

   // ****************************************************************
   // Spin-up
   // ****************************************************************
   assign spin_active  = (spin_ms_reg != 15'h0000);
   // zero to non-zero start; zero level disables
   assign spin_trigger = (base_duty_reg == fan_two_pkg::duty_zero) && (base_duty != fan_two_pkg::duty_zero)
                         && (spinup_duty_level != 4'h0) && (spinup_duration_code != 4'h0);
   assign spinning     = spin_active || spin_trigger;
   assign duty_next    = spinning ? max8(spinup_duty, base_duty) : base_duty;

   // duration decode and countdown
   // A fresh zero to non-zero step reloads, even over a count that is ending
   always_ff @(posedge clock) begin
      if (reset) begin
         spin_ms_reg <= 15'h0000;
      end else if (spin_trigger) begin
         spin_ms_reg <= fan_two_pkg::spinup_ms_table[spinup_duration_code];
      end else if (ms_tick_reg && spin_active) begin
         spin_ms_reg <= spin_ms_reg - 15'h0001;
      end
   end

   // Applied duty and previous base duty
   always_ff @(posedge clock) begin
      if (reset) begin
         duty_reg      <= fan_two_pkg::duty_zero;
         base_duty_reg <= fan_two_pkg::duty_zero;
      end else begin
         duty_reg      <= duty_next;
         base_duty_reg <= base_duty;
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // global lock guards configuration but not the lock flag
   assign write_source       = reg_write && !config_lock && reg_addr == fan_two_pkg::source_select_addr;
   assign write_override_any = reg_write && reg_addr == fan_two_pkg::override_lock_addr;
   assign write_override_cfg = write_override_any && !config_lock;
   assign write_spinup       = reg_write && !config_lock && reg_addr == fan_two_pkg::spinup_config_addr;
   // bound processor overheat sets lock only when enabled
   assign lock_set   = hot_lock_enable && processor_hot_bind && hot_stable_reg[0];
   assign lock_clear = write_override_any && !reg_wdata[fan_two_pkg::hot_lock_flag_bit];

   always_ff @(posedge clock) begin
      if (reset) begin
         source_select_reg <= fan_two_pkg::source_select_reset;
         override_ctl_reg  <= fan_two_pkg::override_lock_reset;
         spinup_config_reg <= fan_two_pkg::spinup_config_reset;
      end else begin
         if (write_source) begin
            source_select_reg <= reg_wdata;
         end
         if (write_override_cfg) begin
            override_ctl_reg <= reg_wdata;
         end
         if (write_spinup) begin
            spinup_config_reg <= reg_wdata;
         end
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         hot_lock_flag_reg <= 1'b0;
      end else if (lock_set) begin
         hot_lock_flag_reg <= 1'b1;
      end else if (lock_clear) begin
         hot_lock_flag_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // applied level; zero while spinning
   assign applied_code  = spin_active ? 4'h0 : duty_to_code(duty_reg, high_freq_map_select);
   assign override_read = {applied_code, hot_lock_flag_reg, override_ctl_reg[2:0]};
   assign read_value    = (reg_addr == fan_two_pkg::source_select_addr) ? source_select_reg :
                          (reg_addr == fan_two_pkg::override_lock_addr) ? override_read :
                          (reg_addr == fan_two_pkg::spinup_config_addr) ? spinup_config_reg : 8'h00;

   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= read_value;
      end
   end

   // ****************************************************************
   // Output stage
   // ****************************************************************
   fan_two_wave wave (
      .clock   (clock),
      .reset   (reset),
      .duty    (duty_reg),
      .invert  (output_polarity_invert),
      .fan_pin (fan_output_two)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   AST_LOCK_NEEDS_ENABLE: assert property ((!hot_lock_enable && !hot_lock_flag_reg) |=> !hot_lock_flag_reg)
      else $error("lock flag set without lock enable");
   AST_LOCK_SET: assert property (lock_set |=> hot_lock_flag_reg)
      else $error("bound overheat did not set lock flag");
   AST_LOCK_FULL: assert property (hot_lock_flag_reg |=> duty_reg == fan_two_pkg::duty_full)
      else $error("locked output not at full duty");
   AST_LOCK_CLEAR: assert property ((lock_clear && !lock_set) |=> !hot_lock_flag_reg)
      else $error("zero write did not clear lock flag");
   AST_LOCK_WRITABLE: assert property ((config_lock && lock_clear && !lock_set) |=> !hot_lock_flag_reg)
      else $error("lock flag not writable under global lock");
   AST_ZONE_MAX: assert property (zone_table_bind[0] |=> duty_reg >= $past(zone_duty_one))
      else $error("output below bound zone request");
   AST_OVERRIDE: assert property (manual_duty_enable |=> duty_reg >= $past(override_duty))
      else $error("output below manual level");
   AST_SPIN_READ: assert property ((spin_active && reg_read && reg_addr == fan_two_pkg::override_lock_addr)
      |=> reg_rdata[7:4] == 4'h0)
      else $error("manual level field nonzero during spin-up");
   AST_SPIN_START: assert property (spin_trigger |=> spin_active ##0 duty_reg >= $past(spinup_duty))
      else $error("spin-up did not start");
   AST_SPIN_OFF: assert property ((spinup_duty_level == 4'h0 && !spin_active) |=> !spin_active)
      else $error("spin-up ran with zero level");

   CVR_LOCK: cover property (lock_set ##1 hot_lock_flag_reg ##[1:20] lock_clear);
   CVR_SPIN: cover property (spin_trigger ##1 spin_active);
   CVR_OVERRIDE: cover property (manual_duty_enable && duty_reg == override_duty && duty_reg != 8'h00);

endmodule : fan_two_control

// *** testbench/fan_model.sv ***
// Fan model: counts how many clocks the drive pin is high per PWM period.
// Assumes the fixed 255-clock period of the output and the bench clock.
module fan_model (
   // Clock and pin
   input  wire logic       clock,
   input  wire logic       fan_pin,
   // Measured high time
   output logic      [7:0] high_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] phase_reg = 8'h00;
   logic [7:0] acc_reg   = 8'h00;
   // Free-running windows; a steady duty gives the same count at any phase
   always @(posedge clock) begin
      if (phase_reg == 8'hFE) begin
         high_count <= acc_reg + {7'h00, fan_pin};
         acc_reg    <= 8'h00;
         phase_reg  <= 8'h00;
      end else begin
         acc_reg   <= acc_reg + {7'h00, fan_pin};
         phase_reg <= phase_reg + 8'h01;
      end
   end
endmodule : fan_model

// *** testbench/fan_two_control_bench.sv ***
// Bench for the second fan output control block.
// Assumes a 20 MHz clock and a shortened millisecond tick of 4 cycles.
module fan_two_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, config_lock = 0, hot = 0, fan_pin;
   logic reg_hot = 0, hf_map = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd, high_count;
   logic [7:0] zone_one = 8'h00, zone_two = 8'h00, zone_three = 8'h00, zone_four = 8'h00;
   int err_total = 0, total_checks = 0;
   fan_two_control #(.ms_tick_cycles(4)) i_fan_two_control (.clock(clock), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .config_lock(config_lock), .high_freq_map_select(hf_map),
      .zone_duty_one(zone_one), .zone_duty_two(zone_two), .zone_duty_three(zone_three),
      .zone_duty_four(zone_four), .processor_overheat_input(hot), .regulator_overheat_input(reg_hot),
      .fan_output_two(fan_pin));
   fan_model i_fan_model (.clock(clock), .fan_pin(fan_pin), .high_count(high_count));
   // Clock generation
   initial begin
      forever #25 clock = ~clock;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask : wait_cycles
   // Strobes go up just after an edge and drop after the taking edge
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); #5 reg_addr = a; reg_wdata = d; reg_write = 1;
      @(posedge clock); #5 reg_write = 0;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
      @(posedge clock); #5 reg_addr = a; reg_read = 1;
      @(posedge clock); #5 reg_read = 0;
      check(reg_rdata & mask, exp);
   endtask : reg_chk
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic reset_values;
      reg_chk(8'hCC, 8'h00, 8'hFF);
      reg_chk(8'hCD, 8'h00, 8'hFF);
      reg_chk(8'hCE, 8'h00, 8'hFF);
      reg_chk(8'hC0, 8'h00, 8'hFF);
   endtask : reset_values
   // Zone one rises from zero with level 3 and code 1 (100 ms = 400 cycles)
   task automatic spin_up;
      reg_wr(8'hCC, 8'h01);
      reg_wr(8'hCE, 8'h23);
      zone_one = 8'h22;
      wait_cycles(20);
      reg_chk(8'hCD, 8'h00, 8'hFF);
      wait_cycles(350);
      reg_chk(8'hCD, 8'h00, 8'hFF);
      wait_cycles(100);
      reg_chk(8'hCD, 8'h20, 8'hFF);
   endtask : spin_up
   task automatic manual_override;
      reg_wr(8'hCD, 8'h51);
      wait_cycles(520);
      check(high_count, 8'h55);
      reg_chk(8'hCD, 8'h51, 8'hFF);
      reg_wr(8'hCD, 8'h00);
   endtask : manual_override
   // Unbound zone two asks for more but must be ignored
   task automatic zone_maximum;
      reg_wr(8'hCC, 8'h05);
      zone_one = 8'h40; zone_two = 8'hFF; zone_three = 8'h80; zone_four = 8'h70;
      wait_cycles(520);
      check(high_count, 8'h80);
   endtask : zone_maximum
   task automatic polarity;
      zone_three = 8'hFF;
      reg_wr(8'hCD, 8'h02);
      wait_cycles(520);
      check(high_count, 8'h00);
      reg_wr(8'hCD, 8'h00);
      wait_cycles(520);
      check(high_count, 8'hFF);
   endtask : polarity
   // Regulator ramp climbs one step per tick; the fast map then governs the manual level
   task automatic ramp_and_map;
      reg_wr(8'hCE, 8'h00);
      reg_wr(8'hCC, 8'h40);
      reg_hot = 1;
      wait_cycles(100);
      reg_chk(8'hCD, 8'h10, 8'hFF);
      wait_cycles(1000);
      reg_chk(8'hCD, 8'hF0, 8'hFF);
      reg_hot = 0;
      hf_map = 1;
      reg_wr(8'hCC, 8'h00);
      reg_wr(8'hCD, 8'h31);
      wait_cycles(520);
      check(high_count, 8'h60);
      reg_chk(8'hCD, 8'h31, 8'hFF);
      hf_map = 0;
      reg_wr(8'hCD, 8'h00);
   endtask : ramp_and_map
   // Lock sets from bound processor hot, then clears under the global lock
   task automatic hot_lock;
      zone_one = 8'h10; zone_three = 8'h10;
      reg_wr(8'hCC, 8'h15);
      reg_wr(8'hCD, 8'h04);
      hot = 1;
      wait_cycles(20);
      reg_chk(8'hCD, 8'hFC, 8'hFF);
      config_lock = 1; hot = 0;
      wait_cycles(10);
      reg_wr(8'hCD, 8'h04);
      reg_chk(8'hCD, 8'h04, 8'h0F);
   endtask : hot_lock
   // ****************************************************************
   // Verdict and main sequence
   // ****************************************************************
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Watchdog: the sequence needs about 4300 cycles
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      stop_test();
   end
   initial begin
      wait_cycles(12);
      reset = 0;
      reset_values();
      spin_up();
      manual_override();
      zone_maximum();
      polarity();
      ramp_and_map();
      hot_lock();
      stop_test();
   end
endmodule : fan_two_control_bench
